// >>> verilog/iopms_top.v
// Notes on behaviour
// - Control bit zero selects microcontroller I/O.
// - Output uses data-out; input read via data-in.
// - Ports C, D: no control, equations enable logic.
// - Logic output tri-stated by term or direction.
// - Address drives by term, or direction and control.
// - Address out on A,B: low a3-a0, high a7-a4.
// - Config bit 7 makes port A bus buffer.
// - Bus buffer tri-stated unless a select asserted.
// - Selects qualified by program-fetch strobe.
// - Driver enable is direction OR product term.
// - Logic modes fixed; others changeable at run time.
// - Port C scan pins dedicated, never driven.
// - Group BC reaches C pins 2,3,4,7 only.
// - Registers mapped in window, ordinary bus cycles.
// - Enable-out registers show current driver state.
//
// Top of the I/O port mode selector: APB register window, four ports.
// Assumes pins arrive asynchronously; logic-array terms arrive on mclk.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "iopms_defines.vh"
module iopms_top #(
    parameter [7:0] CELL_MASK_A = 8'h00,  // Port A pins under logic equations
    parameter [7:0] CELL_MASK_B = 8'h00,  // Port B pins under logic equations
    parameter [7:0] CELL_MASK_C = 8'h00,  // Port C pins under logic equations
    parameter [2:0] CELL_MASK_D = 3'h0,   // Port D pins under logic equations
    parameter PERIPH_FETCH_QUAL = 1'b1    // Qualify selects by fetch strobe
) (
    input wire mclk,                 // Clock, 40 MHz
    input wire arst_n,               // Async reset, low
    input wire psel,                 // APB select
    input wire penable,              // APB enable
    input wire pwrite,               // APB write
    input wire [7:0] paddr,          // APB byte address
    input wire [31:0] pwdata,        // APB write data
    output wire pready,              // APB ready
    output reg [31:0] prdata,        // APB read data
    output wire pslverr,             // APB error
    input wire [7:0] latchedAddr,    // Latched address a7-a0
    input wire [7:0] mcuDataOut,     // Microcontroller data to peripheral
    output reg [7:0] mcuDataIn,      // Peripheral data to microcontroller
    input wire periph_select_0,      // Peripheral select equation 0
    input wire periph_select_1,      // Peripheral select equation 1
    input wire program_fetch_strobe, // Program fetch strobe, high active
    input wire [7:0] output_cell_group_ab, // Group AB cells to A and B
    input wire [7:0] output_cell_group_bc, // Group BC cells to C
    input wire [2:0] extChipSel,     // External chip-select cells for D
    input wire [7:0] oeTermA,        // Output-enable terms port A
    input wire [7:0] oeTermB,        // Output-enable terms port B
    input wire [7:0] oeTermC,        // Output-enable terms port C
    input wire [2:0] oeTermD,        // Output-enable terms port D
    input wire [7:0] portAIn,        // Port A pin levels
    input wire [7:0] portBIn,        // Port B pin levels
    input wire [7:0] portCIn,        // Port C pin levels
    input wire [2:0] portDIn,        // Port D pin levels
    output wire [7:0] portAOut,      // Port A drive value
    output wire [7:0] portAOe,       // Port A enables
    output wire [7:0] portBOut,      // Port B drive value
    output wire [7:0] portBOe,       // Port B enables
    output wire [7:0] portCOut,      // Port C drive value
    output wire [7:0] portCOe,       // Port C enables
    output wire [2:0] portDOut,      // Port D drive value
    output wire [2:0] portDOe,       // Port D enables
    output wire [7:0] input_cell_ab, // Synchronised port B inputs to cells
    output wire [7:0] input_cell_c   // Synchronised C inputs to cells
);
    // ************************************************
    // Registers
    // ************************************************
    reg [7:0] ctrlA_ff;
    reg [7:0] ctrlB_ff;
    reg [7:0] dirA_ff;
    reg [7:0] dirB_ff;
    reg [7:0] dirC_ff;
    reg [2:0] dirD_ff;
    reg [7:0] doutA_ff;
    reg [7:0] doutB_ff;
    reg [7:0] doutC_ff;
    reg [2:0] doutD_ff;
    reg [7:0] memCfg_ff;
    wire [7:0] syncA;
    wire [7:0] syncB;
    wire [7:0] syncC;
    wire [2:0] syncD;
    wire [7:0] oeA;
    wire [7:0] oeB;
    wire [7:0] oeC;
    wire [7:0] outC;
    wire periphMode;
    wire periphDrive;
    wire wrEn;
    wire rdEn;
    reg addrHit;
    // One write strobe per register
    wire wrCtrlA;
    wire wrCtrlB;
    wire wrDirA;
    wire wrDirB;
    wire wrDirC;
    wire wrDirD;
    wire wrDoutA;
    wire wrDoutB;
    wire wrDoutC;
    wire wrDoutD;
    wire wrMemCfg;

    // single-cycle access
    // No wait states: every register answers in its access cycle
    assign pready = 1'b1;
    assign wrEn = psel & penable & pwrite;
    // Read data loads in the setup cycle so it stands through the access phase
    assign rdEn = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~addrHit;

    function isAddr;
        input [7:0] a;
        input [7:0] off;
        begin
            isAddr = (a == off);
        end
    endfunction

    always @*
    begin
        case (paddr)
            `IOPMS_OFF_CTRL_A, `IOPMS_OFF_CTRL_B, `IOPMS_OFF_DIR_A, `IOPMS_OFF_DIR_B,
            `IOPMS_OFF_DIR_C, `IOPMS_OFF_DIR_D, `IOPMS_OFF_DOUT_A, `IOPMS_OFF_DOUT_B,
            `IOPMS_OFF_DOUT_C, `IOPMS_OFF_DOUT_D, `IOPMS_OFF_DIN_A, `IOPMS_OFF_DIN_B,
            `IOPMS_OFF_DIN_C, `IOPMS_OFF_DIN_D, `IOPMS_OFF_ENOUT_A, `IOPMS_OFF_ENOUT_B,
            `IOPMS_OFF_ENOUT_C, `IOPMS_OFF_ENOUT_D, `IOPMS_OFF_MEMCFG:
                addrHit = 1'b1;
            default:
                addrHit = 1'b0;
        endcase
    end

    // ************************************************
    // Write strobes
    // ************************************************
    assign wrCtrlA = wrEn & isAddr(paddr, `IOPMS_OFF_CTRL_A);
    assign wrCtrlB = wrEn & isAddr(paddr, `IOPMS_OFF_CTRL_B);
    assign wrDirA = wrEn & isAddr(paddr, `IOPMS_OFF_DIR_A);
    assign wrDirB = wrEn & isAddr(paddr, `IOPMS_OFF_DIR_B);
    assign wrDirC = wrEn & isAddr(paddr, `IOPMS_OFF_DIR_C);
    assign wrDirD = wrEn & isAddr(paddr, `IOPMS_OFF_DIR_D);
    assign wrDoutA = wrEn & isAddr(paddr, `IOPMS_OFF_DOUT_A);
    assign wrDoutB = wrEn & isAddr(paddr, `IOPMS_OFF_DOUT_B);
    assign wrDoutC = wrEn & isAddr(paddr, `IOPMS_OFF_DOUT_C);
    assign wrDoutD = wrEn & isAddr(paddr, `IOPMS_OFF_DOUT_D);
    assign wrMemCfg = wrEn & isAddr(paddr, `IOPMS_OFF_MEMCFG);

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrlA_ff <= `IOPMS_REG_RESET;
            ctrlB_ff <= `IOPMS_REG_RESET;
            dirA_ff <= `IOPMS_REG_RESET;
            dirB_ff <= `IOPMS_REG_RESET;
            dirC_ff <= `IOPMS_REG_RESET;
            dirD_ff <= `IOPMS_PORTD_RESET;
            doutA_ff <= `IOPMS_REG_RESET;
            doutB_ff <= `IOPMS_REG_RESET;
            doutC_ff <= `IOPMS_REG_RESET;
            doutD_ff <= `IOPMS_PORTD_RESET;
            memCfg_ff <= `IOPMS_REG_RESET;
        end
        else
        begin
            if (wrCtrlA)
                ctrlA_ff <= pwdata[7:0];
            if (wrCtrlB)
                ctrlB_ff <= pwdata[7:0];
            if (wrDirA)
                dirA_ff <= pwdata[7:0];
            if (wrDirB)
                dirB_ff <= pwdata[7:0];
            if (wrDirC)
                dirC_ff <= pwdata[7:0];
            if (wrDirD)
                dirD_ff <= pwdata[2:0];
            if (wrDoutA)
                doutA_ff <= pwdata[7:0];
            if (wrDoutB)
                doutB_ff <= pwdata[7:0];
            if (wrDoutC)
                doutC_ff <= pwdata[7:0];
            if (wrDoutD)
                doutD_ff <= pwdata[2:0];
            if (wrMemCfg)
                memCfg_ff <= pwdata[7:0];
        end
    end

    // ************************************************
    // Pin inputs
    // ************************************************
    iopms_pin_sync #(.W(8)) uSyncA (.mclk(mclk), .arst_n(arst_n), .pinIn(portAIn), .pinSync(syncA));
    iopms_pin_sync #(.W(8)) uSyncB (.mclk(mclk), .arst_n(arst_n), .pinIn(portBIn), .pinSync(syncB));
    iopms_pin_sync #(.W(8)) uSyncC (.mclk(mclk), .arst_n(arst_n), .pinIn(portCIn), .pinSync(syncC));
    iopms_pin_sync #(.W(3)) uSyncD (.mclk(mclk), .arst_n(arst_n), .pinIn(portDIn), .pinSync(syncD));

    assign input_cell_ab = syncB;
    // Scan pins belong to the scan logic; the cells never see them
    // scan pins hidden from cells
    assign input_cell_c = syncC & ~`IOPMS_PC_SCAN_MASK;

    // ************************************************
    // Port multiplexers
    // ************************************************
    assign periphMode = memCfg_ff[`IOPMS_MEMCFG_PIO_BIT];
    // With qualification off a data-space window can turn the buffer on
    // fetch-strobe qualification
    assign periphDrive = (periph_select_0 | periph_select_1) & (~PERIPH_FETCH_QUAL | program_fetch_strobe);

    // address a7-a0 on A and B
    iopms_pin_mux uMuxA (
        .dirBits(dirA_ff), .ctrlBits(ctrlA_ff), .doutBits(doutA_ff), .addrBits(latchedAddr),
        .cellBits(output_cell_group_ab), .cellMask(CELL_MASK_A), .oeTerm(oeTermA),
        .busMode(periphMode), .busDrive(periphDrive), .busData(mcuDataOut),
        .blockMask(`IOPMS_REG_RESET), .pinOut(portAOut), .pinOe(oeA));
    // Port B has no peripheral mode, so its bus inputs stay idle
    iopms_pin_mux uMuxB (
        .dirBits(dirB_ff), .ctrlBits(ctrlB_ff), .doutBits(doutB_ff), .addrBits(latchedAddr),
        .cellBits(output_cell_group_ab), .cellMask(CELL_MASK_B), .oeTerm(oeTermB),
        .busMode(1'b0), .busDrive(1'b0), .busData(`IOPMS_REG_RESET),
        .blockMask(`IOPMS_REG_RESET), .pinOut(portBOut), .pinOe(oeB));
    iopms_pin_mux uMuxC (
        .dirBits(dirC_ff), .ctrlBits(`IOPMS_REG_RESET), .doutBits(doutC_ff), .addrBits(`IOPMS_REG_RESET),
        .cellBits(output_cell_group_bc), .cellMask(CELL_MASK_C & `IOPMS_PC_CELL_MASK), .oeTerm(oeTermC),
        .busMode(1'b0), .busDrive(1'b0), .busData(`IOPMS_REG_RESET),
        .blockMask(`IOPMS_PC_SCAN_MASK), .pinOut(outC), .pinOe(oeC));

    assign portAOe = oeA;
    assign portBOe = oeB;
    assign portCOut = outC;
    assign portCOe = oeC;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gPortD
            assign portDOut[g] = CELL_MASK_D[g] ? extChipSel[g] : doutD_ff[g];
            assign portDOe[g] = dirD_ff[g] | oeTermD[g];
        end
    endgenerate

    // ************************************************
    // Read path
    // ************************************************
    // Port A pins to the microcontroller bus, one flop after the filter
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            mcuDataIn <= `IOPMS_REG_RESET;
        else
            mcuDataIn <= syncA;
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= 32'h00000000;
        else if (rdEn)
        begin
            case (paddr)
                `IOPMS_OFF_CTRL_A: prdata <= {24'h000000, ctrlA_ff};
                `IOPMS_OFF_CTRL_B: prdata <= {24'h000000, ctrlB_ff};
                `IOPMS_OFF_DIR_A: prdata <= {24'h000000, dirA_ff};
                `IOPMS_OFF_DIR_B: prdata <= {24'h000000, dirB_ff};
                `IOPMS_OFF_DIR_C: prdata <= {24'h000000, dirC_ff};
                `IOPMS_OFF_DIR_D: prdata <= {29'h00000000, dirD_ff};
                `IOPMS_OFF_DOUT_A: prdata <= {24'h000000, doutA_ff};
                `IOPMS_OFF_DOUT_B: prdata <= {24'h000000, doutB_ff};
                `IOPMS_OFF_DOUT_C: prdata <= {24'h000000, doutC_ff};
                `IOPMS_OFF_DOUT_D: prdata <= {29'h00000000, doutD_ff};
                `IOPMS_OFF_DIN_A: prdata <= {24'h000000, syncA};
                `IOPMS_OFF_DIN_B: prdata <= {24'h000000, syncB};
                `IOPMS_OFF_DIN_C: prdata <= {24'h000000, syncC};
                `IOPMS_OFF_DIN_D: prdata <= {29'h00000000, syncD};
                `IOPMS_OFF_ENOUT_A: prdata <= {24'h000000, oeA};
                `IOPMS_OFF_ENOUT_B: prdata <= {24'h000000, oeB};
                `IOPMS_OFF_ENOUT_C: prdata <= {24'h000000, oeC};
                `IOPMS_OFF_ENOUT_D: prdata <= {29'h00000000, portDOe};
                `IOPMS_OFF_MEMCFG: prdata <= {24'h000000, memCfg_ff};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> verilog/iopms_defines.vh
// Constants for the I/O port mode selector: APB register map and field layouts.
// Assumes inclusion by bare name from the design files.
`ifndef IOPMS_DEFINES_VH
`define IOPMS_DEFINES_VH

`define IOPMS_ADDR_W 8
`define IOPMS_DATA_W 32
`define IOPMS_PORT_W 8
`define IOPMS_PORTD_W 3

// Register byte offsets inside the I/O register window
`define IOPMS_OFF_CTRL_A 8'h00
`define IOPMS_OFF_CTRL_B 8'h04
`define IOPMS_OFF_DIR_A 8'h08
`define IOPMS_OFF_DIR_B 8'h0C
`define IOPMS_OFF_DIR_C 8'h10
`define IOPMS_OFF_DIR_D 8'h14
`define IOPMS_OFF_DOUT_A 8'h18
`define IOPMS_OFF_DOUT_B 8'h1C
`define IOPMS_OFF_DOUT_C 8'h20
`define IOPMS_OFF_DOUT_D 8'h24
`define IOPMS_OFF_DIN_A 8'h28
`define IOPMS_OFF_DIN_B 8'h2C
`define IOPMS_OFF_DIN_C 8'h30
`define IOPMS_OFF_DIN_D 8'h34
`define IOPMS_OFF_ENOUT_A 8'h38
`define IOPMS_OFF_ENOUT_B 8'h3C
`define IOPMS_OFF_ENOUT_C 8'h40
`define IOPMS_OFF_ENOUT_D 8'h44
`define IOPMS_OFF_MEMCFG 8'h48

`define IOPMS_MEMCFG_PIO_BIT 7
`define IOPMS_REG_RESET 8'h00
`define IOPMS_PORTD_RESET 3'h0

// Port C scan pins 0,1,5,6 are dedicated; cell group BC reaches pins 2,3,4,7
`define IOPMS_PC_SCAN_MASK 8'h63
`define IOPMS_PC_CELL_MASK 8'h9C

`define IOPMS_SEL_DOUT 2'h0
`define IOPMS_SEL_ADDR 2'h1
`define IOPMS_SEL_CELL 2'h2
`define IOPMS_SEL_BUS 2'h3

`endif

// >>> verilog/iopms_pin_sync.v
// Three-flop synchroniser for a vector of pin inputs.
// Assumes pins are asynchronous to mclk; output follows once flops 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module iopms_pin_sync #(
    parameter W = 8
) (
    input wire mclk,           // Clock
    input wire arst_n,         // Async reset, low
    input wire [W-1:0] pinIn,  // Raw pin levels
    output wire [W-1:0] pinSync // Filtered pin levels
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    reg [W-1:0] out_ff;
    wire [W-1:0] nxt_out;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : gBit
            // Only accept a change once the two later stages agree
            assign nxt_out[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : out_ff[g];
        end
    endgenerate

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            out_ff <= {W{1'b0}};
        end
        else
        begin
            s1_ff <= pinIn;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign pinSync = out_ff;
endmodule
`default_nettype wire

// >>> verilog/iopms_pin_mux.v
// Output multiplexer and driver enable for one 8-bit port.
// Assumes select and data come from registers or configuration on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "iopms_defines.vh"
module iopms_pin_mux (
    input wire [7:0] dirBits,     // Direction register
    input wire [7:0] ctrlBits,    // Control register, zero where none
    input wire [7:0] doutBits,    // Data-out register
    input wire [7:0] addrBits,    // Latched address mapped to pins
    input wire [7:0] cellBits,    // Output cell values
    input wire [7:0] cellMask,    // Pins assigned to logic equations
    input wire [7:0] oeTerm,      // Output-enable product terms
    input wire busMode,           // Peripheral data-bus mode active
    input wire busDrive,          // A peripheral select asserted
    input wire [7:0] busData,     // Bus write data
    input wire [7:0] blockMask,   // Dedicated pins, never driven
    output reg [7:0] pinOut,      // Pin output value
    output reg [7:0] pinOe        // Pin driver enable, high drives
);
    integer i;
    always @*
    begin
        pinOut = 8'h00;
        pinOe = 8'h00;
        for (i = 0; i < 8; i = i + 1)
        begin
            if (blockMask[i])
            begin
                pinOut[i] = 1'b0;
                pinOe[i] = 1'b0;
            end
            else if (busMode)
            begin
                pinOut[i] = busData[i];
                pinOe[i] = busDrive;
            end
            else
            begin
                if (ctrlBits[i])
                    pinOut[i] = addrBits[i];
                else if (cellMask[i])
                    pinOut[i] = cellBits[i];
                else
                    pinOut[i] = doutBits[i];
                pinOe[i] = dirBits[i] | oeTerm[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/iopms_monitor.sv
// Concurrent checks on the ports of the I/O port mode selector top.
// Assumes one clock domain, mclk, and the async active-low reset arst_n.
`timescale 1ns/1ps
`default_nettype none
module iopms_monitor (
    input wire logic mclk, // Clock
    input wire logic arst_n, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic pslverr, // APB error
    input wire logic [31:0] prdata, // APB read data
    input wire logic [7:0] mcuDataIn, // Port A data to bus
    input wire logic [7:0] oeTermB, // Enable terms B
    input wire logic [7:0] oeTermC, // Enable terms C
    input wire logic [2:0] oeTermD, // Enable terms D
    input wire logic [7:0] portAIn, // Port A pins
    input wire logic [7:0] portBIn, // Port B pins
    input wire logic [7:0] portCIn, // Port C pins
    input wire logic [7:0] portBOe, // Port B enables
    input wire logic [7:0] portCOe, // Port C enables
    input wire logic [2:0] portDOe, // Port D enables
    input wire logic [7:0] input_cell_ab, // Synced B
    input wire logic [7:0] input_cell_c // Synced C
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ************************************************
    // Driver enables and dedicated pins
    // ************************************************
    scan_pins_idle_a: assert property ((portCOe & 8'h63) == 8'h00)
        else $error("scan pin driven");
    term_drives_b_a: assert property ((oeTermB & ~portBOe) == 8'h00)
        else $error("port B term did not enable driver");
    term_drives_c_a: assert property ((oeTermC & 8'h9C & ~portCOe) == 8'h00)
        else $error("port C term did not enable driver");
    term_drives_d_a: assert property ((oeTermD & ~portDOe) == 3'h0)
        else $error("port D term did not enable driver");

    // ************************************************
    // Pin input paths, checked once the pins have settled
    // ************************************************
    bus_input_follow_a: assert property ($stable(portAIn) [*8] |-> mcuDataIn == portAIn)
        else $error("port A input not passed to bus");
    cell_ab_follow_a: assert property ($stable(portBIn) [*8] |-> input_cell_ab == portBIn)
        else $error("port B input not passed to cells");
    cell_c_follow_a: assert property ($stable(portCIn) [*8] |-> input_cell_c == (portCIn & 8'h9C))
        else $error("port C input cells wrong");

    // ************************************************
    // Register window
    // ************************************************
    read_data_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data changed without a read");
    window_error_a: assert property (pslverr == (psel && penable && (paddr > 8'h48 || paddr[1:0] != 2'h0)))
        else $error("error response wrong for address");
endmodule

bind iopms_top iopms_monitor u_mon (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .prdata(prdata), .mcuDataIn(mcuDataIn),
    .oeTermB(oeTermB), .oeTermC(oeTermC), .oeTermD(oeTermD), .portAIn(portAIn), .portBIn(portBIn),
    .portCIn(portCIn), .portBOe(portBOe), .portCOe(portCOe), .portDOe(portDOe),
    .input_cell_ab(input_cell_ab), .input_cell_c(input_cell_c));
`default_nettype wire

// >>> verification/iopms_pin_model.sv
// Pins of one port with an external device wired to them.
// Assumes the external side only drives pins that the block leaves released.
`timescale 1ns/1ps
`default_nettype none
module iopms_pin_model #(
    parameter W = 8
) (
    input wire logic [W-1:0] dutOut, // Block drive value
    input wire logic [W-1:0] dutOe, // Block enables
    input wire logic [W-1:0] extVal, // Device drive value
    input wire logic [W-1:0] extEn, // Device enables
    output logic [W-1:0] pinLevel // Resolved pin level
);
    // A released pin shows the inverse of the block drive value, so a stale read fails
    always_comb
    begin
        for (int i = 0; i < W; i++)
            pinLevel[i] = extEn[i] ? extVal[i] : (dutOe[i] ? dutOut[i] : ~dutOut[i]);
    end
endmodule
`default_nettype wire

// >>> verification/io_port_mode_selector_bench.sv
// Self-checking bench for the I/O port mode selector over APB.
// Assumes the partner pin model and the bound monitor are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "iopms_defines.vh"
module io_port_mode_selector_bench;
    logic mclk, arst_n, psel, penable, pwrite, sel0, sel1, fetch, err;
    logic [7:0] paddr, latchedAddr, mcuDataOut, cellAb, cellBc, oeA, oeB, oeC, extB, extEnB;
    logic [7:0] extA, extEnA, extC, extEnC;
    logic [2:0] ecs, oeD, extD, extEnD;
    logic [31:0] pwdata, rd;
    wire pready, pslverr;
    wire [31:0] prdata;
    wire [7:0] mcuDataIn, aIn, bIn, cIn, aOut, aOe, bOut, bOe, cOut, cOe;
    wire [2:0] dIn, dOut, dOe;
    int miscompares, nTests;

    iopms_top #(.CELL_MASK_C(8'h9C)) DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .latchedAddr(latchedAddr), .mcuDataOut(mcuDataOut), .mcuDataIn(mcuDataIn),
        .periph_select_0(sel0), .periph_select_1(sel1), .program_fetch_strobe(fetch),
        .output_cell_group_ab(cellAb), .output_cell_group_bc(cellBc), .extChipSel(ecs), .oeTermA(oeA),
        .oeTermB(oeB), .oeTermC(oeC), .oeTermD(oeD), .portAIn(aIn), .portBIn(bIn), .portCIn(cIn),
        .portDIn(dIn), .portAOut(aOut), .portAOe(aOe), .portBOut(bOut), .portBOe(bOe), .portCOut(cOut),
        .portCOe(cOe), .portDOut(dOut), .portDOe(dOe), .input_cell_ab(), .input_cell_c());
    iopms_pin_model #(.W(8)) padA (.dutOut(aOut), .dutOe(aOe), .extVal(extA), .extEn(extEnA), .pinLevel(aIn));
    iopms_pin_model #(.W(8)) padB (.dutOut(bOut), .dutOe(bOe), .extVal(extB), .extEn(extEnB), .pinLevel(bIn));
    iopms_pin_model #(.W(8)) padC (.dutOut(cOut), .dutOe(cOe), .extVal(extC), .extEn(extEnC), .pinLevel(cIn));
    iopms_pin_model #(.W(3)) padD (.dutOut(dOut), .dutOe(dOe), .extVal(extD), .extEn(extEnD), .pinLevel(dIn));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ************************************************
    // Bus and compare tasks
    // ************************************************
    // Read data stands from the setup edge, so it is taken at the access edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    // ************************************************
    // Test sequence
    // ************************************************
    initial
    begin
        {arst_n, psel, penable, pwrite, sel0, sel1, fetch} = 7'h00;
        {paddr, latchedAddr, mcuDataOut, cellAb, oeA, oeB, oeC, extB, extEnB} = 72'h0;
        cellBc = 8'hE7;
        {extA, extEnA, extC, extEnC} = 32'h0;
        {ecs, oeD, extD, extEnD} = 12'h000;
        pwdata = 32'h0;
        miscompares = 0;
        nTests = 0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i <= 'h48; i += 4)
            if (i < 'h28 || i >= 'h38) rdChk("reset value", i[7:0], 32'h0);
        apb(1'b1, `IOPMS_OFF_DIR_B, 32'h0F);
        apb(1'b1, `IOPMS_OFF_DOUT_B, 32'hA5);
        chk("portBOe io", 32'h0F, {24'h0, bOe});
        chk("portBOut io", 32'h05, {24'h0, bOut & 8'h0F});
        rdChk("enout B", `IOPMS_OFF_ENOUT_B, 32'h0F);
        rdChk("dout B", `IOPMS_OFF_DOUT_B, 32'hA5);
        extB <= 8'h30;
        extEnB <= 8'hF0;
        repeat (6) @(posedge mclk);
        rdChk("din B", `IOPMS_OFF_DIN_B, 32'h35);
        extEnB <= 8'h00;
        latchedAddr <= 8'h3C;
        apb(1'b1, `IOPMS_OFF_CTRL_B, 32'hFF);
        apb(1'b1, `IOPMS_OFF_DIR_B, 32'hFF);
        chk("addr out B", 32'h3C, {24'h0, bOut});
        apb(1'b1, `IOPMS_OFF_CTRL_A, 32'hFF);
        chk("ctrl only A", 32'h00, {24'h0, aOe});
        apb(1'b1, `IOPMS_OFF_DIR_A, 32'hFF);
        chk("addr out A", 32'h3C, {24'h0, aOut});
        apb(1'b1, `IOPMS_OFF_DIR_C, 32'hFF);
        apb(1'b1, `IOPMS_OFF_DOUT_C, 32'hFF);
        chk("portCOe", 32'h9C, {24'h0, cOe});
        chk("cells on C", 32'h84, {24'h0, cOut & 8'h9C});
        apb(1'b1, `IOPMS_OFF_DIR_C, 32'h00);
        oeC <= 8'h04;
        @(posedge mclk);
        @(posedge mclk);
        chk("cell tri-state", 32'h04, {24'h0, cOe});
        extC <= 8'h5A;
        extEnC <= 8'hFB;
        repeat (4) @(posedge mclk);
        rdChk("din C", `IOPMS_OFF_DIN_C, 32'h5E);
        oeD <= 3'h5;
        apb(1'b1, `IOPMS_OFF_DOUT_D, 32'h7);
        chk("portDOe term", 32'h5, {29'h0, dOe});
        chk("portDOut", 32'h5, {29'h0, dOut & 3'h5});
        rdChk("enout D", `IOPMS_OFF_ENOUT_D, 32'h5);
        apb(1'b0, 8'h4C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        mcuDataOut <= 8'h5A;
        apb(1'b1, `IOPMS_OFF_MEMCFG, 32'h80);
        chk("bus idle", 32'h00, {24'h0, aOe});
        sel0 <= 1'b1;
        fetch <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        chk("bus enable", 32'hFF, {24'h0, aOe});
        chk("bus data", 32'h5A, {24'h0, aOut});
        fetch <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        chk("no fetch", 32'h00, {24'h0, aOe});
        extA <= 8'hC3;
        extEnA <= 8'hFF;
        repeat (6) @(posedge mclk);
        chk("bus input", 32'hC3, {24'h0, mcuDataIn});
        extEnA <= 8'h00;
        sel0 <= 1'b0;
        sel1 <= 1'b1;
        fetch <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        chk("select 1", 32'hFF, {24'h0, aOe});
        chk("port B kept", 32'h3C, {24'h0, bOut});
        finish_test();
    end
endmodule
`default_nettype wire
